// >>> common/itc_pkg.sv
// shared constants for the input threshold command registers
package itc_pkg;

  // command codes that select a register or start the nonvolatile copy
  localparam logic [7:0]  CMD_SCALE_LOOP    = 8'h29;  // feedback scale ratio word
  localparam logic [7:0]  CMD_VOUT_FLOOR    = 8'h2B;  // output-voltage floor word
  localparam logic [7:0]  CMD_VIN_TURN_ON   = 8'h35;  // input turn-on threshold word
  localparam logic [7:0]  CMD_VIN_TURN_OFF  = 8'h36;  // input turn-off threshold word
  localparam logic [7:0]  CMD_STORE_ALL     = 8'h11;  // copy settings to nonvolatile memory

  // linear word layout
  localparam int          EXP_LSB           = 11;     // exponent occupies bits 15:11
  localparam logic [4:0]  EXP_QUARTER_VOLT  = 5'h1E;  // -2, one count is 0.25 V
  localparam logic [4:0]  EXP_VOUT_MODE     = 5'h17;  // -9, one floor count is ~1.95 mV

  // input thresholds, in 0.25 V counts
  localparam logic [7:0]  VON_MIN           = 8'h11;  // 4.25 V
  localparam logic [7:0]  VON_MAX           = 8'h1F;  // 7.75 V
  localparam logic [3:0]  VON_RESET_LOW     = 4'h2;   // 18 counts, 4.5 V
  localparam logic [7:0]  VOFF_MIN          = 8'h10;  // 4.0 V
  localparam logic [7:0]  VOFF_MAX          = 8'h1E;  // 7.5 V
  localparam logic [3:0]  VOFF_RESET_LOW    = 4'h0;   // 16 counts, 4.0 V
  localparam logic [10:0] QV_FIXED_MANT     = 11'h010; // mantissa bit 4 is hard-wired
  localparam logic [15:0] VON_RESET_WORD    = 16'hF012;
  localparam logic [15:0] VOFF_RESET_WORD   = 16'hF010;

  // output floor, in 2^-9 V counts
  localparam logic [15:0] VMIN_WR_MASK      = 16'h0FFF; // bits 15:12 read as zero
  localparam logic [15:0] VMIN_LO_SCALE1    = 16'h00B3; // 179, also the reset value
  localparam logic [15:0] VMIN_HI_SCALE1    = 16'h0300; // 768
  localparam logic [15:0] VMIN_LO_SCALE05   = 16'h0166; // 358
  localparam logic [15:0] VMIN_HI_SCALE05   = 16'h0600; // 1536

  // feedback scale ratio mantissa (exponent -2)
  localparam logic [2:0]  SCALE_ONE         = 3'h4;   // ratio 1, reset value
  localparam logic [2:0]  SCALE_HALF        = 3'h2;   // ratio 0.5

  // nonvolatile copy sequencer
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_ON    = 5'h02,
    ST_OFF   = 5'h04,
    ST_MIN   = 5'h08,
    ST_SCALE = 5'h10
  } itc_nvm_state_t;

endpackage : itc_pkg

// >>> verilog/itc_lin_round.sv
`timescale 1ns/10ps
// converts a written linear word into 0.25 V counts, rounded to nearest
module itc_lin_round (
  input  wire logic [15:0] word_in,  // linear word as written by the host
  output logic      [7:0]  qv_out,   // rounded value in 0.25 V counts
  output logic             ovf_out   // negative, or too large at an exponent of -2 or coarser
);

  // exponent and mantissa are both two's complement
  logic signed [4:0]  exp_s;   // written exponent
  logic        [4:0]  shift;   // shift amount for either direction
  logic        [26:0] wide;    // headroom for the largest left shift

  // rounding happens before range checks so that 4.3 V lands on 4.25 V
  always_comb begin
    exp_s   = $signed(word_in[15:11]);
    shift   = 5'h00;
    wide    = 27'h0;
    qv_out  = 8'h00;
    ovf_out = 1'b0;
    if (word_in[10]) begin
      // a negative voltage is never a legal threshold
      ovf_out = 1'b1;
    end else if (exp_s >= $signed(itc_pkg::EXP_QUARTER_VOLT)) begin
      // coarser or equal weight: exact, only overflow to check
      shift   = 5'(exp_s - $signed(itc_pkg::EXP_QUARTER_VOLT));
      wide    = {16'h0000, word_in[10:0]} << shift;
      ovf_out = |wide[26:8];
      qv_out  = wide[7:0];
    end else begin
      // finer weight: add half a step, then drop the extra bits
      shift   = 5'($signed(itc_pkg::EXP_QUARTER_VOLT) - exp_s);
      wide    = ({16'h0000, word_in[10:0]} + (27'h1 << (shift - 5'h01))) >> shift;
      qv_out  = wide[7:0];
    end
  end

endmodule : itc_lin_round

// >>> verilog/itc_regs.sv
`timescale 1ns/10ps
module itc_regs (
  input  wire logic        clk_in,                          // 40 MHz core clock
  input  wire logic        rst_n_in,                        // synchronous, active low
  input  wire logic        cmd_wr_in,                       // write command strobe
  input  wire logic        cmd_rd_in,                       // read command strobe
  input  wire logic [7:0]  cmd_code_in,                     // command code
  input  wire logic [15:0] cmd_data_in,                     // write data word
  input  wire logic        clear_faults_in,                 // clears all sticky flags
  input  wire logic [7:0]  vin_qv_in,                       // measured input, 0.25 V counts
  input  wire logic        startup_ok_in,                   // every other start condition met
  input  wire logic        output_on_in,                    // output stage is on
  input  wire logic [15:0] vout_target_in,                  // requested output, 2^-9 V counts
  output logic      [15:0] rd_data_out,                     // read data
  output logic             rd_valid_out,                    // read data valid pulse
  output logic             cmd_nack_out,                    // unsupported command pulse
  output logic             run_enable_out,                  // input allows operation
  output logic      [15:0] vref_out,                        // reference after floor clamp
  output logic             vout_clamped_out,                // target is being held at floor
  output logic             cml_flag_out,                    // communication flag
  output logic             invalid_data_flag_out,           // invalid data flag
  output logic             miscellaneous_status_flag_out,   // other flag
  output logic             output_voltage_warning_flag_out, // output voltage warning
  output logic             output_limit_warning_flag_out,   // output min/max warning
  output logic             smbalert_out,                    // alert request, active high
  output logic             nvm_wr_out,                      // nonvolatile write pulse
  output logic      [7:0]  nvm_cmd_out,                     // command code being saved
  output logic      [15:0] nvm_data_out,                    // word being saved
  output logic             nvm_busy_out                     // copy sequence running
);

  // stored fields: only writable bits are kept, fixed bits come from constants
  logic [3:0]  von_low_q;       // turn-on mantissa bits 3:0
  logic [3:0]  voff_low_q;      // turn-off mantissa bits 3:0
  logic [15:0] vmin_q;          // output floor mantissa
  logic [2:0]  scale_q;         // scale ratio mantissa bits 2:0

  // write decode results
  logic [7:0]  wr_qv;           // rounded threshold from the converter
  logic        wr_ovf;          // converter could not represent it
  logic [7:0]  von_cur;         // current turn-on threshold in counts
  logic [7:0]  voff_cur;        // current turn-off threshold in counts
  logic        wr_on_ok;        // turn-on write accepted
  logic        wr_off_ok;       // turn-off write accepted
  logic        wr_min_ok;       // floor write accepted
  logic        wr_scale_ok;     // scale write accepted
  logic        wr_known;        // write hits a writable command
  logic        wr_reject;       // write carries invalid data

  // floor clamp
  logic        below_floor;     // target under the floor while output on
  logic        clamp_q;         // below_floor one cycle ago
  logic [15:0] vout_eff;        // target after clamp, output volts

  // sticky flags
  logic        cml_d;
  logic        cml_q;
  logic        ivd_d;
  logic        ivd_q;
  logic        oth_d;
  logic        oth_q;
  logic        vfw_d;
  logic        vfw_q;
  logic        lim_d;
  logic        lim_q;

  // read path and copy sequencer
  logic [15:0]    rd_data_q;
  logic           rd_valid_q;
  logic           nack_q;
  logic           run_q;
  logic [15:0]    vref_q;
  logic           nvm_wr_q;
  logic [7:0]     nvm_cmd_q;
  logic [15:0]    nvm_data_q;
  itc_pkg::itc_nvm_state_t nvm_state_q;
  itc_pkg::itc_nvm_state_t nvm_state_d;

  // builds a threshold word from its writable bits
  function automatic logic [15:0] qv_word(input logic [3:0] low);
    qv_word = {itc_pkg::EXP_QUARTER_VOLT, itc_pkg::QV_FIXED_MANT | {7'h00, low}};
  endfunction : qv_word

  // builds the scale ratio word from its writable bits
  function automatic logic [15:0] scale_word(input logic [2:0] mant);
    scale_word = {itc_pkg::EXP_QUARTER_VOLT, 8'h00, mant};
  endfunction : scale_word

  // returns the read word for a command code, zero for unknown codes
  function automatic logic [15:0] reg_word(input logic [7:0] code, input logic [3:0] on_l,
                                           input logic [3:0] off_l, input logic [15:0] vmin,
                                           input logic [2:0] scl);
    unique case (code)
      itc_pkg::CMD_VIN_TURN_ON:  reg_word = qv_word(on_l);
      itc_pkg::CMD_VIN_TURN_OFF: reg_word = qv_word(off_l);
      itc_pkg::CMD_VOUT_FLOOR:   reg_word = vmin & itc_pkg::VMIN_WR_MASK;
      itc_pkg::CMD_SCALE_LOOP:   reg_word = scale_word(scl);
      default:                   reg_word = 16'h0000;
    endcase
  endfunction : reg_word

  // write data rounding shared by both threshold commands
  itc_lin_round u_round (
    .word_in (cmd_data_in),
    .qv_out  (wr_qv),
    .ovf_out (wr_ovf)
  );

  // current thresholds rebuilt from their fixed upper bit
  assign von_cur  = {4'h1, von_low_q};
  assign voff_cur = {4'h1, voff_low_q};

  // range and ordering checks on every write candidate
  always_comb begin
    wr_on_ok    = 1'b0;
    wr_off_ok   = 1'b0;
    wr_min_ok   = 1'b0;
    wr_scale_ok = 1'b0;
    wr_known    = 1'b0;
    if (cmd_wr_in) begin
      unique case (cmd_code_in)
        itc_pkg::CMD_VIN_TURN_ON: begin
          wr_known = 1'b1;
          // the rounded count must sit in range and above turn-off
          wr_on_ok = !wr_ovf && wr_qv >= itc_pkg::VON_MIN && wr_qv <= itc_pkg::VON_MAX
                     && wr_qv > voff_cur;
        end
        itc_pkg::CMD_VIN_TURN_OFF: begin
          wr_known  = 1'b1;
          wr_off_ok = !wr_ovf && wr_qv >= itc_pkg::VOFF_MIN && wr_qv <= itc_pkg::VOFF_MAX
                      && wr_qv < von_cur;
        end
        itc_pkg::CMD_VOUT_FLOOR: begin
          wr_known = 1'b1;
          // the legal floor window follows the scale ratio already in force
          if (scale_q == itc_pkg::SCALE_ONE) begin
            wr_min_ok = cmd_data_in >= itc_pkg::VMIN_LO_SCALE1
                        && cmd_data_in <= itc_pkg::VMIN_HI_SCALE1;
          end else begin
            wr_min_ok = cmd_data_in >= itc_pkg::VMIN_LO_SCALE05
                        && cmd_data_in <= itc_pkg::VMIN_HI_SCALE05;
          end
        end
        itc_pkg::CMD_SCALE_LOOP: begin
          wr_known    = 1'b1;
          // read-only bits are ignored, only the writable field decides
          wr_scale_ok = cmd_data_in[2:0] == itc_pkg::SCALE_ONE
                        || cmd_data_in[2:0] == itc_pkg::SCALE_HALF;
        end
        default: wr_known = 1'b0;
      endcase
    end
  end

  // a known write that fails its check is invalid data
  assign wr_reject = wr_known && !(wr_on_ok || wr_off_ok || wr_min_ok || wr_scale_ok);

  // turn-on threshold: the fixed upper bit is implied, never stored
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      von_low_q <= itc_pkg::VON_RESET_LOW;
    end else if (wr_on_ok) begin
      von_low_q <= wr_qv[3:0];
    end
  end

  // turn-off threshold: same layout as turn-on
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      voff_low_q <= itc_pkg::VOFF_RESET_LOW;
    end else if (wr_off_ok) begin
      voff_low_q <= wr_qv[3:0];
    end
  end

  // output floor; a changed scale does not rescale it, software reprograms it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vmin_q <= itc_pkg::VMIN_LO_SCALE1;
    end else if (wr_min_ok) begin
      vmin_q <= cmd_data_in & itc_pkg::VMIN_WR_MASK;
    end
  end

  // feedback scale ratio
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scale_q <= itc_pkg::SCALE_ONE;
    end else if (wr_scale_ok) begin
      scale_q <= cmd_data_in[2:0];
    end
  end

  // input window: start above turn-on, stop at or below turn-off
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_q <= 1'b0;
    end else if (run_q && vin_qv_in <= voff_cur) begin
      run_q <= 1'b0;
    end else if (!run_q && vin_qv_in > von_cur && startup_ok_in) begin
      run_q <= 1'b1;
    end
  end

  // floor comparison is done in output volts, both in 2^-9 V counts
  assign below_floor = output_on_in && (vout_target_in < vmin_q);
  assign vout_eff    = below_floor ? vmin_q : vout_target_in;

  // reference follows the scale ratio; half ratio halves the reference
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      vref_q  <= 16'h0000;
      clamp_q <= 1'b0;
    end else begin
      vref_q  <= (scale_q == itc_pkg::SCALE_HALF) ? {1'b0, vout_eff[15:1]} : vout_eff;
      clamp_q <= below_floor;
    end
  end

  // flag next values: a new event always wins over a clear in the same cycle
  always_comb begin
    cml_d = clear_faults_in ? 1'b0 : cml_q;
    ivd_d = clear_faults_in ? 1'b0 : ivd_q;
    oth_d = clear_faults_in ? 1'b0 : oth_q;
    vfw_d = clear_faults_in ? 1'b0 : vfw_q;
    lim_d = clear_faults_in ? 1'b0 : lim_q;
    if (wr_reject) begin
      cml_d = 1'b1;
      ivd_d = 1'b1;
    end
    // only the entry into clamping raises the warnings, so a clear sticks
    if (below_floor && !clamp_q) begin
      oth_d = 1'b1;
      vfw_d = 1'b1;
      lim_d = 1'b1;
    end
  end

  // sticky flags and the alert they drive
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cml_q        <= 1'b0;
      ivd_q        <= 1'b0;
      oth_q        <= 1'b0;
      vfw_q        <= 1'b0;
      lim_q        <= 1'b0;
      smbalert_out <= 1'b0;
    end else begin
      cml_q        <= cml_d;
      ivd_q        <= ivd_d;
      oth_q        <= oth_d;
      vfw_q        <= vfw_d;
      lim_q        <= lim_d;
      smbalert_out <= cml_d | ivd_d | oth_d | vfw_d | lim_d;
    end
  end

  // read answer one cycle after the strobe; unknown codes answer zero and nack
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
      nack_q     <= 1'b0;
    end else begin
      rd_valid_q <= cmd_rd_in;
      rd_data_q  <= cmd_rd_in ? reg_word(cmd_code_in, von_low_q, voff_low_q, vmin_q, scale_q)
                              : 16'h0000;
      // the store command is a write without data meaning; anything else unknown nacks
      nack_q     <= (cmd_rd_in && reg_word(cmd_code_in, 4'h0, 4'h0, 16'h0000, 3'h0) == 16'h0000
                     && cmd_code_in != itc_pkg::CMD_VOUT_FLOOR)
                    || (cmd_wr_in && !wr_known && cmd_code_in != itc_pkg::CMD_STORE_ALL);
    end
  end

  // copy sequencer: one word per cycle, a store during a copy is ignored
  always_comb begin
    nvm_state_d = nvm_state_q;
    unique case (nvm_state_q)
      itc_pkg::ST_IDLE: begin
        if (cmd_wr_in && cmd_code_in == itc_pkg::CMD_STORE_ALL) begin
          nvm_state_d = itc_pkg::ST_ON;
        end
      end
      itc_pkg::ST_ON:    nvm_state_d = itc_pkg::ST_OFF;
      itc_pkg::ST_OFF:   nvm_state_d = itc_pkg::ST_MIN;
      itc_pkg::ST_MIN:   nvm_state_d = itc_pkg::ST_SCALE;
      itc_pkg::ST_SCALE: nvm_state_d = itc_pkg::ST_IDLE;
      default:           nvm_state_d = itc_pkg::ST_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      nvm_state_q  <= itc_pkg::ST_IDLE;
      nvm_busy_out <= 1'b0;
    end else begin
      nvm_state_q  <= nvm_state_d;
      nvm_busy_out <= nvm_state_d != itc_pkg::ST_IDLE; // flop, not a state decode
    end
  end

  // copy outputs: live register contents, so a write during a copy may be seen
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      nvm_wr_q   <= 1'b0;
      nvm_cmd_q  <= 8'h00;
      nvm_data_q <= 16'h0000;
    end else begin
      nvm_wr_q   <= nvm_state_q != itc_pkg::ST_IDLE;
      nvm_cmd_q  <= 8'h00;
      nvm_data_q <= 16'h0000;
      unique case (nvm_state_q)
        itc_pkg::ST_ON: begin
          nvm_cmd_q  <= itc_pkg::CMD_VIN_TURN_ON;
          nvm_data_q <= qv_word(von_low_q);
        end
        itc_pkg::ST_OFF: begin
          nvm_cmd_q  <= itc_pkg::CMD_VIN_TURN_OFF;
          nvm_data_q <= qv_word(voff_low_q);
        end
        itc_pkg::ST_MIN: begin
          nvm_cmd_q  <= itc_pkg::CMD_VOUT_FLOOR;
          nvm_data_q <= vmin_q;
        end
        itc_pkg::ST_SCALE: begin
          nvm_cmd_q  <= itc_pkg::CMD_SCALE_LOOP;
          nvm_data_q <= scale_word(scale_q);
        end
        default: nvm_cmd_q <= 8'h00;
      endcase
    end
  end

  // outputs straight from flip-flops
  assign rd_data_out                     = rd_data_q;
  assign rd_valid_out                    = rd_valid_q;
  assign cmd_nack_out                    = nack_q;
  assign run_enable_out                  = run_q;
  assign vref_out                        = vref_q;
  assign vout_clamped_out                = clamp_q;
  assign cml_flag_out                    = cml_q;
  assign invalid_data_flag_out           = ivd_q;
  assign miscellaneous_status_flag_out   = oth_q;
  assign output_voltage_warning_flag_out = vfw_q;
  assign output_limit_warning_flag_out   = lim_q;
  assign nvm_wr_out                      = nvm_wr_q;
  assign nvm_cmd_out                     = nvm_cmd_q;
  assign nvm_data_out                    = nvm_data_q;

endmodule : itc_regs

// >>> bench/itc_regs_checker.sv
`timescale 1ns/10ps
// watches the command port, the sticky flags and the copy sequencer
module itc_regs_checker (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        cmd_wr_in,
  input wire logic        cmd_rd_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic        clear_faults_in,
  input wire logic [15:0] rd_data_out,
  input wire logic        rd_valid_out,
  input wire logic        cml_flag_out,
  input wire logic        invalid_data_flag_out,
  input wire logic        miscellaneous_status_flag_out,
  input wire logic        output_voltage_warning_flag_out,
  input wire logic        output_limit_warning_flag_out,
  input wire logic        vout_clamped_out,
  input wire logic        smbalert_out,
  input wire logic        nvm_wr_out,
  input wire logic [7:0]  nvm_cmd_out,
  input wire logic [15:0] nvm_data_out,
  input wire logic        nvm_busy_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // native-exponent writes only, so no rounding can hide a range slip
  logic        qv_wr;  // write with the quarter-volt exponent
  logic [10:0] mant;   // written mantissa
  assign qv_wr = cmd_wr_in && (cmd_data_in[15:11] == itc_pkg::EXP_QUARTER_VOLT);
  assign mant  = cmd_data_in[10:0];
  sequence s_bad;
    cml_flag_out && invalid_data_flag_out && smbalert_out;
  endsequence
  sequence s_copy;
    nvm_busy_out ##1 (nvm_wr_out && nvm_cmd_out == itc_pkg::CMD_VIN_TURN_ON)
    ##1 (nvm_wr_out && nvm_cmd_out == itc_pkg::CMD_VIN_TURN_OFF)
    ##1 (nvm_wr_out && nvm_cmd_out == itc_pkg::CMD_VOUT_FLOOR)
    ##1 (nvm_wr_out && nvm_cmd_out == itc_pkg::CMD_SCALE_LOOP);
  endsequence
  property p_on_range;
    qv_wr && cmd_code_in == itc_pkg::CMD_VIN_TURN_ON && (mant < 11'h011 || mant > 11'h01F)
    |=> s_bad;
  endproperty
  property p_off_range;
    qv_wr && cmd_code_in == itc_pkg::CMD_VIN_TURN_OFF && (mant < 11'h010 || mant > 11'h01E)
    |=> s_bad;
  endproperty
  property p_scale;
    cmd_wr_in && cmd_code_in == itc_pkg::CMD_SCALE_LOOP && cmd_data_in[2:0] != 3'h4
    && cmd_data_in[2:0] != 3'h2 |=> s_bad;
  endproperty
  property p_alert;
    cml_flag_out || miscellaneous_status_flag_out |-> smbalert_out;
  endproperty
  property p_sticky;
    cml_flag_out && !clear_faults_in |=> cml_flag_out;
  endproperty
  // threshold words always read back with the fixed exponent and upper mantissa
  property p_rd_fixed;
    cmd_rd_in && (cmd_code_in == 8'h35 || cmd_code_in == 8'h36)
    |=> rd_valid_out && rd_data_out[15:4] == 12'hF01;
  endproperty
  property p_nvm_fixed;
    nvm_wr_out && (nvm_cmd_out == 8'h35 || nvm_cmd_out == 8'h36) |-> nvm_data_out[15:4] == 12'hF01;
  endproperty
  property p_store;
    cmd_wr_in && cmd_code_in == itc_pkg::CMD_STORE_ALL && !nvm_busy_out |=> s_copy;
  endproperty
  property p_clamp;
    $rose(vout_clamped_out) |-> ##[0:1] (miscellaneous_status_flag_out
    && output_voltage_warning_flag_out && output_limit_warning_flag_out);
  endproperty
  a_on_range:  assert property (p_on_range) else $error("turn-on range not refused");
  a_off_range: assert property (p_off_range) else $error("turn-off range not refused");
  a_scale:     assert property (p_scale) else $error("bad scale not refused");
  a_alert:     assert property (p_alert) else $error("flag without alert");
  a_sticky:    assert property (p_sticky) else $error("flag dropped");
  a_rd_fixed:  assert property (p_rd_fixed) else $error("fixed bits lost");
  a_nvm_fixed: assert property (p_nvm_fixed) else $error("bad saved word");
  a_store:     assert property (p_store) else $error("copy order wrong");
  a_clamp:     assert property (p_clamp) else $error("clamp without warnings");
endmodule : itc_regs_checker

bind itc_regs itc_regs_checker i_chk (.clk_in, .rst_n_in, .cmd_wr_in, .cmd_rd_in, .cmd_code_in,
  .cmd_data_in, .clear_faults_in, .rd_data_out, .rd_valid_out, .cml_flag_out,
  .invalid_data_flag_out, .miscellaneous_status_flag_out, .output_voltage_warning_flag_out,
  .output_limit_warning_flag_out, .vout_clamped_out, .smbalert_out, .nvm_wr_out, .nvm_cmd_out,
  .nvm_data_out, .nvm_busy_out);

// >>> bench/itc_host_model.sv
`timescale 1ns/10ps
// command master; changes its lines 1 ns after the rising edge
module itc_host_model (
  input  wire logic        clk_in,       // core clock
  input  wire logic [15:0] rd_data_in,   // read word
  input  wire logic        rd_valid_in,  // read word valid
  output logic             cmd_wr_out,   // write strobe
  output logic             cmd_rd_out,   // read strobe
  output logic      [7:0]  cmd_code_out, // command code
  output logic      [15:0] cmd_data_out  // write word
);
  initial begin
    cmd_wr_out   = 1'b0;
    cmd_rd_out   = 1'b0;
    cmd_code_out = 8'h00;
    cmd_data_out = 16'h0000;
  end
  // released lines carry the inverse so a stale word never looks live
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    cmd_wr_out   = 1'b1;
    cmd_code_out = c;
    cmd_data_out = d;
    @(posedge clk_in);
    #1;
    cmd_wr_out   = 1'b0;
    cmd_code_out = ~c;
    cmd_data_out = ~d;
  endtask : wr
  // answer stands one cycle, taken right after the edge that carries it
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
    @(posedge clk_in);
    #1;
    cmd_rd_out   = 1'b1;
    cmd_code_out = c;
    @(posedge clk_in);
    #1;
    cmd_rd_out   = 1'b0;
    cmd_code_out = ~c;
    d            = rd_data_in;
    v            = rd_valid_in;
  endtask : rd
endmodule : itc_host_model

// >>> bench/itc_regs_tb.sv
`timescale 1ns/10ps
// command-level checks of the threshold and floor registers
module itc_regs_tb;
  localparam int LIMIT = 3000;  // cycles; the run needs about 100
  logic        clk_in = 1'b0;   // 40 MHz
  logic        rst_n_in = 1'b0; // low for two edges
  logic        clr = 1'b0;      // sticky flag clear
  logic        ok = 1'b0;       // other start conditions met
  logic        on = 1'b0;       // output stage on
  logic [7:0]  vin = 8'h00;     // input voltage, 0.25 V counts
  logic [15:0] tgt = 16'h0200;  // requested output
  logic        wr, rd, valid, nack, run, clamped, cml, ivd, miscellaneous_status_flag, output_voltage_warning_flag, lim, alert, nvm_wr, busy;
  logic [7:0]  code, nvm_cmd;
  logic [15:0] data, rdata, vref, nvm_data;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  always #12.5 clk_in = ~clk_in;
  itc_host_model i_host (.clk_in(clk_in), .rd_data_in(rdata), .rd_valid_in(valid),
    .cmd_wr_out(wr), .cmd_rd_out(rd), .cmd_code_out(code), .cmd_data_out(data));
  itc_regs i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_wr_in(wr), .cmd_rd_in(rd),
    .cmd_code_in(code), .cmd_data_in(data), .clear_faults_in(clr), .vin_qv_in(vin),
    .startup_ok_in(ok), .output_on_in(on), .vout_target_in(tgt), .rd_data_out(rdata),
    .rd_valid_out(valid), .cmd_nack_out(nack), .run_enable_out(run), .vref_out(vref),
    .vout_clamped_out(clamped), .cml_flag_out(cml), .invalid_data_flag_out(ivd),
    .miscellaneous_status_flag_out(miscellaneous_status_flag), .output_voltage_warning_flag_out(output_voltage_warning_flag),
    .output_limit_warning_flag_out(lim), .smbalert_out(alert), .nvm_wr_out(nvm_wr),
    .nvm_cmd_out(nvm_cmd), .nvm_data_out(nvm_data), .nvm_busy_out(busy));
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    i_host.rd(c, d, v);
    chk_bit(v, 1'b1);
    chk_word(d, exp);
  endtask : rd_chk
  // one write, the expected refusal flags, then a clear so the next case starts clean
  task automatic try_wr(input logic [7:0] c, input logic [15:0] d, input logic bad);
    i_host.wr(c, d);
    chk_bit(cml, bad);
    chk_bit(ivd, bad);
    chk_bit(alert, bad);
    clr = 1'b1;
    tick();
    clr = 1'b0;
  endtask : try_wr
  task automatic t_thresholds;
    rd_chk(8'h35, 16'hF012);
    rd_chk(8'h36, 16'hF010);
    try_wr(8'h35, 16'hF01F, 1'b0);
    try_wr(8'h36, 16'hF01E, 1'b0);
    try_wr(8'h36, 16'hF01F, 1'b1);
    try_wr(8'h35, 16'hF01E, 1'b1);
    try_wr(8'h36, 16'hF014, 1'b0);
    try_wr(8'h35, 16'hE829, 1'b0);
    rd_chk(8'h35, 16'hF015);
    try_wr(8'h35, 16'hF00F, 1'b1);
    try_wr(8'h35, 16'hF020, 1'b1);
    rd_chk(8'h35, 16'hF015);
    try_wr(8'h36, 16'hF00F, 1'b1);
    try_wr(8'h36, 16'hF015, 1'b1);
    rd_chk(8'h36, 16'hF014);
  endtask : t_thresholds
  task automatic t_floor;
    rd_chk(8'h2B, 16'h00B3);
    rd_chk(8'h29, 16'hF004);
    try_wr(8'h2B, 16'h00B2, 1'b1);
    try_wr(8'h2B, 16'h0301, 1'b1);
    try_wr(8'h2B, 16'h0300, 1'b0);
    try_wr(8'h29, 16'hF003, 1'b1);
    try_wr(8'h29, 16'hF002, 1'b0);
    try_wr(8'h2B, 16'h0165, 1'b1);
    try_wr(8'h2B, 16'h0601, 1'b1);
    try_wr(8'h2B, 16'h0600, 1'b0);
    rd_chk(8'h2B, 16'h0600);
    try_wr(8'h29, 16'hF004, 1'b0);
    try_wr(8'h2B, 16'h0200, 1'b0);
    i_host.wr(8'h3C, 16'h0000);
    chk_bit(nack, 1'b1);
  endtask : t_floor
  // copy order and words follow the live register values
  task automatic t_store;
    logic [7:0]  cs [4] = '{8'h35, 8'h36, 8'h2B, 8'h29};
    logic [15:0] ds [4] = '{16'hF015, 16'hF014, 16'h0200, 16'hF004};
    i_host.wr(itc_pkg::CMD_STORE_ALL, 16'h0000);
    chk_bit(busy, 1'b1);
    for (int i = 0; i < 4; i++) begin
      tick();
      chk_bit(nvm_wr, 1'b1);
      chk_word({8'h00, nvm_cmd}, {8'h00, cs[i]});
      chk_word(nvm_data, ds[i]);
    end
  endtask : t_store
  // turn-on is 21 counts, turn-off 20
  task automatic t_window;
    tick();
    vin = 8'h16;
    tick();
    chk_bit(run, 1'b0);
    ok  = 1'b1;
    vin = 8'h15;
    tick();
    chk_bit(run, 1'b0);
    vin = 8'h16;
    tick();
    chk_bit(run, 1'b1);
    vin = 8'h15;
    tick();
    chk_bit(run, 1'b1);
    vin = 8'h14;
    tick();
    chk_bit(run, 1'b0);
  endtask : t_window
  task automatic t_clamp;
    tgt = 16'h0100;
    tick();
    chk_bit(clamped, 1'b0);
    on = 1'b1;
    tick();
    chk_bit(clamped, 1'b1);
    chk_word(vref, 16'h0200);
    chk_word({12'h000, miscellaneous_status_flag, output_voltage_warning_flag, lim, alert}, 16'h000F);
  endtask : t_clamp
  task automatic final_report;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    t_thresholds();
    t_floor();
    t_store();
    t_window();
    t_clamp();
    final_report();
  end
endmodule : itc_regs_tb
